/* rtl/eep_pkg.sv */
// Purpose: shared constants and types of the two-wire serial memory target
// Assumes: system clock of 100 MHz; register bus is AHB-Lite with 32-bit data
// Notes:   all sizes, offsets and timing counts live here by name
package eep_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and programming time
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned NS_PER_MS        = 1000000;
    localparam int unsigned PROG_TIME_MS     = 5;
    // longest time, so the division rounds down
    localparam int unsigned PROG_CYCLES_DFLT = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int          TMR_W            = 20;

    ////////////////////////////////////////////////////////////////////////////////
    // array organisation
    localparam int MEM_BYTES  = 2048;
    localparam int ADDR_W     = 11;
    localparam int PAGE_BYTES = 16;
    localparam int OFS_W      = 4;
    localparam int PAGE_W     = 7;
    localparam int SEL_W      = 3;
    localparam int CNT_W      = 3;
    localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses inside the slave window
    localparam int         REG_AW      = 8;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_PROGS   = 8'h08;
    localparam logic [7:0] REG_BLOCKED = 8'h0C;
    localparam int CTRL_WP_BIT   = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PIN_BIT  = 1;
    localparam int STAT_PROT_BIT = 2;
    localparam int HTRANS_ACT    = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // state machines
    typedef enum logic [3:0] {
        LK_IDLE = 4'h0, LK_DEV = 4'h1, LK_ACKD = 4'h2, LK_WADR = 4'h3, LK_ACKW = 4'h4,
        LK_WDAT = 4'h5, LK_ACKB = 4'h6, LK_RDAT = 4'h7, LK_RACK = 4'h8
    } eep_link_st_t;

    typedef enum logic [1:0] {
        PG_IDLE = 2'h0, PG_BUSY = 2'h1, PG_COMMIT = 2'h2
    } eep_prog_st_t;

endpackage : eep_pkg

/* rtl/eep_sync.sv */
// Purpose: two-flop level synchroniser into the system clock
// Assumes: inputs are slow levels compared with the clock
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module eep_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    // two stages, nothing else reads meta_q
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : eep_sync

/* rtl/eep_link.sv */
// Purpose: serial-clock side of the target: start, address, ack, page buffer, read out
// Assumes: data changes only while the serial clock is low, except start and stop
// Notes:   stop is seen by the system side, since the serial clock stands still after it
`timescale 1ns/1ps
module eep_link #(
    parameter logic [3:0] DEV_CODE = 4'h6 // arbitrary device-type code
) (
    input  wire logic                                  i_scl,
    input  wire logic                                  i_rst_n,
    input  wire logic                                  i_sda,
    input  wire logic                                  i_busy,
    input  wire logic [7:0]                            i_rd_data,
    output logic      [eep_pkg::ADDR_W-1:0]            o_addr,
    output logic                                       o_sda_oe,
    output logic      [eep_pkg::PAGE_BYTES-1:0][7:0]   o_buf_data,
    output logic      [eep_pkg::PAGE_BYTES-1:0]        o_buf_mask,
    output logic      [eep_pkg::PAGE_W-1:0]            o_buf_page,
    output logic                                       o_buf_tgl
);
    import eep_pkg::*;

    typedef struct packed {
        eep_link_st_t                st;
        logic [CNT_W-1:0]            cnt;
        logic [7:0]                  sh;
        logic [SEL_W-1:0]            page;
        logic [ADDR_W-1:0]           addr;
        logic                        oe;
        logic [1:0]                  busy_s;
        logic [PAGE_BYTES-1:0][7:0]  bd;
        logic [PAGE_BYTES-1:0]       bm;
        logic [PAGE_W-1:0]           bp;
        logic                        tgl;
        logic                        stt;
    } eep_link_q_t;

    eep_link_q_t q, d;
    logic        sda_pos_q;
    logic        start_tgl_q;
    logic [7:0]  byte_in;
    logic        start;

    ////////////////////////////////////////////////////////////////////////////////
    // incoming bits are taken on the rising serial clock edge
    always_ff @(posedge i_scl or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sda_pos_q <= 1'b1;
        end else begin
            sda_pos_q <= i_sda;
        end
    end

    // a fall of the data line while the clock is high flips this flag; after a stop the clock
    // stands high with no rising edge, so rising-edge samples alone would miss the next start
    always_ff @(negedge i_sda or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_tgl_q <= 1'b0;
        end else if (i_scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // flag moved since the last falling clock edge: start or repeated start
    assign start = start_tgl_q ^ q.stt;

    ////////////////////////////////////////////////////////////////////////////////
    // protocol engine, advanced on the falling edge so the line changes while clock is low
    always_comb begin
        byte_in  = {q.sh[6:0], sda_pos_q};
        d        = q;
        d.busy_s = {q.busy_s[0], i_busy};
        d.stt    = start_tgl_q; // flag settled long before the fall
        d.cnt    = q.cnt + 3'h1;
        d.sh     = byte_in;
        d.oe     = 1'b0; // released unless a state pulls it low
        if (start) begin
            d.st  = LK_DEV;
            d.cnt = '0;
        end else begin
            unique case (q.st)
                LK_IDLE: d.cnt = q.cnt;
                LK_DEV: if (q.cnt == LAST_BIT) begin
                    // busy programming: no ack, poll again later
                    if (byte_in[7:4] == DEV_CODE && !q.busy_s[1]) begin
                        d.st   = LK_ACKD;
                        d.oe   = 1'b1;
                        d.page = byte_in[SEL_W:1];
                    end else begin
                        d.st = LK_IDLE;
                    end
                end
                LK_ACKD: begin
                    d.cnt = '0;
                    if (q.sh[0]) begin
                        d.st = LK_RDAT;
                        d.sh = i_rd_data;
                        d.oe = ~i_rd_data[7];
                    end else begin
                        d.st  = LK_WADR;
                        d.bm  = '0;
                        d.tgl = ~q.tgl; // fresh write frame for the system side
                    end
                end
                LK_WADR: if (q.cnt == LAST_BIT) begin
                    d.addr = {q.page, byte_in};
                    d.oe   = 1'b1;
                    d.st   = LK_ACKW;
                end
                LK_ACKW: begin
                    d.st  = LK_WDAT;
                    d.cnt = '0;
                end
                LK_WDAT: if (q.cnt == LAST_BIT) begin
                    // bytes land in the page buffer; protection is applied at commit
                    d.bd[q.addr[OFS_W-1:0]] = byte_in;
                    d.bm[q.addr[OFS_W-1:0]] = 1'b1;
                    d.bp                    = q.addr[ADDR_W-1:OFS_W];
                    d.addr[OFS_W-1:0]       = q.addr[OFS_W-1:0] + 4'h1;
                    d.oe                    = 1'b1;
                    d.st                    = LK_ACKB;
                end
                LK_ACKB: begin
                    d.st  = LK_WDAT;
                    d.cnt = '0;
                end
                LK_RDAT: begin
                    d.sh = {q.sh[6:0], 1'b0};
                    if (q.cnt == LAST_BIT) begin
                        d.st   = LK_RACK;
                        d.addr = q.addr + 11'h001; // whole array rolls over
                    end else begin
                        d.oe = ~q.sh[6];
                    end
                end
                LK_RACK: begin
                    d.cnt = '0;
                    if (!sda_pos_q) begin
                        d.st = LK_RDAT;
                        d.sh = i_rd_data;
                        d.oe = ~i_rd_data[7];
                    end else begin
                        d.st = LK_IDLE;
                    end
                end
                default: d.st = LK_IDLE;
            endcase
        end
    end

    // reset only asserts while the serial clock stands still, so release is safe
    always_ff @(negedge i_scl or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_addr     = q.addr;
    assign o_sda_oe   = q.oe;
    assign o_buf_data = q.bd;
    assign o_buf_mask = q.bm;
    assign o_buf_page = q.bp;
    assign o_buf_tgl  = q.tgl;

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the serial clock
    default clocking cb @(negedge i_scl);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_dev_end;
        q.st == LK_DEV && q.cnt == LAST_BIT && !start;
    endsequence

    property p_dev_ack;
        s_dev_end and (byte_in[7:4] == DEV_CODE && !q.busy_s[1]) |=> o_sda_oe && q.st == LK_ACKD;
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("address byte not acknowledged");

    property p_busy_nak;
        s_dev_end and q.busy_s[1] |=> !o_sda_oe && q.st == LK_IDLE;
    endproperty
    a_busy_nak: assert property (p_busy_nak) else $error("address acked while programming");

    property p_page_wrap;
        (q.st == LK_WDAT && q.cnt == LAST_BIT && !start) |=>
            q.addr[ADDR_W-1:OFS_W] == $past(q.addr[ADDR_W-1:OFS_W]) &&
            q.addr[OFS_W-1:0] == 4'($past(q.addr[OFS_W-1:0]) + 4'h1);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page write address left its page");

    property p_read_inc;
        (q.st == LK_RDAT && q.cnt == LAST_BIT && !start) |=> q.addr == 11'($past(q.addr) + 11'h001) && !o_sda_oe;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read address not advanced");

endmodule : eep_link

/* rtl/eep_top.sv */
// Purpose: two-wire serial memory target with 2048 bytes, write protect and timed programming
// Assumes: serial clock is a clock port; register bus is AHB-Lite, zero wait states
// Notes:   array is read across domains only while no programming runs
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - array of 2048 individually addressable bytes
// - sample on clock rise, drive after fall
// - data line only pulled low or released
// - protect low allows reads and writes; writes are still refused here while the CTRL protect bit is set
// - protect high blocks all array changes
// - 128 pages of 16, 11-bit address
// - page write up to sixteen bytes
// - partial page programs only received bytes
// - self-timed programming done within 5 ms
// - address byte: type code, page bits, direction
// - acknowledge each byte in ninth clock
// - page write wraps low four bits
// - no address ack while programming runs
module eep_top #(
    parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES_DFLT,
    parameter logic [3:0]  DEV_CODE    = 4'h6 // arbitrary device-type code
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESETN,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic             O_HREADYOUT,
    output logic      [31:0] O_HRDATA,
    output logic             O_HRESP,
    input  wire logic        I_SCL,
    input  wire logic        I_SDA,
    output logic             O_SDA,
    output logic             O_SDA_OE,
    input  wire logic        I_WP
);
    import eep_pkg::*;

    typedef struct packed {
        logic              scl_p;
        logic              sda_p;
        logic              tgl_done;
        eep_prog_st_t      pst;
        logic [TMR_W-1:0]  tmr;
        logic              sw_wp;
        logic [31:0]       progs;
        logic [31:0]       blocked;
        logic              hsel;
        logic              hwr;
        logic [REG_AW-1:0] haddr;
        logic [31:0]       hrdata;
    } eep_top_q_t;

    eep_top_q_t                 q, d;
    logic [1:0]                 rst_s_q;
    logic                       rst_n;
    logic                       scl_s, sda_s, wp_s, tgl_s;
    logic                       stop, prot, busy, commit_req;
    logic                       frame_end;
    logic [ADDR_W-1:0]          link_addr;
    logic [7:0]                 rd_data;
    logic [PAGE_BYTES-1:0][7:0] buf_data;
    logic [PAGE_BYTES-1:0]      buf_mask;
    logic [PAGE_W-1:0]          buf_page;
    logic                       buf_tgl;
    logic [7:0]                 mem [MEM_BYTES];
    logic [TMR_W-1:0]           busy_len_q;
    logic [7:0]                 keep1;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rst_s_q <= 2'b00;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_n = rst_s_q[1];

    // pins and the frame toggle enter the system clock as levels
    eep_sync #(.W(4)) u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (rst_n),
        .i_d     ({I_SCL, I_SDA, I_WP, buf_tgl}),
        .o_q     ({scl_s, sda_s, wp_s, tgl_s})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // serial-clock engine
    eep_link #(.DEV_CODE(DEV_CODE)) u_link (
        .i_scl      (I_SCL),
        .i_rst_n    (rst_n),
        .i_sda      (I_SDA),
        .i_busy     (busy),
        .i_rd_data  (rd_data),
        .o_addr     (link_addr),
        .o_sda_oe   (O_SDA_OE),
        .o_buf_data (buf_data),
        .o_buf_mask (buf_mask),
        .o_buf_page (buf_page),
        .o_buf_tgl  (buf_tgl)
    );

    // open drain: the output level is always low, only the enable moves
    assign O_SDA = 1'b0;

    // array read crosses domains; stable because programming forces no-ack first
    assign rd_data = mem[link_addr];

    ////////////////////////////////////////////////////////////////////////////////
    // stop seen on synchronised pins: data rises while clock stays high
    assign stop       = q.scl_p && scl_s && !q.sda_p && sda_s;
    assign prot       = wp_s | q.sw_wp;
    assign busy       = (q.pst != PG_IDLE);
    // a write frame not yet handled ends at the stop; only one with a data byte asks for programming
    assign frame_end  = stop && (tgl_s != q.tgl_done);
    assign commit_req = frame_end && (buf_mask != '0);

    always_comb begin
        d       = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;

        // programming sequencer
        unique case (q.pst)
            PG_IDLE: begin
                // dummy write frames retire too, else their toggle hides the next real frame
                if (frame_end) begin
                    d.tgl_done = tgl_s;
                end
                if (commit_req && prot) begin
                    d.blocked = q.blocked + 32'h1; // no cycle started
                end else if (commit_req) begin
                    d.pst = PG_BUSY;
                    d.tmr = TMR_W'(PROG_CYCLES - 1);
                end
            end
            PG_BUSY: begin
                d.tmr = q.tmr - 20'h00001;
                if (q.tmr == '0) begin
                    d.pst = PG_COMMIT;
                end
            end
            PG_COMMIT: begin
                d.pst   = PG_IDLE;
                d.progs = q.progs + 32'h1;
            end
            default: d.pst = PG_IDLE;
        endcase

        // register write in the data phase
        if (q.hsel && q.hwr && q.haddr == REG_CTRL) begin
            d.sw_wp = I_HWDATA[CTRL_WP_BIT];
        end

        // address phase; read data taken after the write above so it is never stale, except STATUS protect, built from q.sw_wp
        d.hsel = I_HSEL && I_HREADY && I_HTRANS[HTRANS_ACT];
        if (d.hsel) begin
            d.hwr    = I_HWRITE;
            d.haddr  = I_HADDR[REG_AW-1:0];
            d.hrdata = '0;
            if (!I_HWRITE) begin
                unique case (I_HADDR[REG_AW-1:0])
                    REG_CTRL:    d.hrdata[CTRL_WP_BIT] = d.sw_wp;
                    REG_STATUS: begin
                        d.hrdata[STAT_BUSY_BIT] = busy;
                        d.hrdata[STAT_PIN_BIT]  = wp_s;
                        d.hrdata[STAT_PROT_BIT] = prot;
                    end
                    REG_PROGS:   d.hrdata = d.progs;
                    REG_BLOCKED: d.hrdata = d.blocked;
                    default:     d.hrdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // one commit cycle writes every received byte of the page, untouched bytes stay
    always_ff @(posedge I_CLK) begin
        if (q.pst == PG_COMMIT) begin
            for (int k = 0; k < PAGE_BYTES; k++) begin
                if (buf_mask[k]) begin
                    mem[{buf_page, OFS_W'(k)}] <= buf_data[k];
                end
            end
        end
    end

    // zero wait states, always OKAY
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;
    assign O_HRDATA    = q.hrdata;

    ////////////////////////////////////////////////////////////////////////////////
    // helper: independent length of the current programming run
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_len_q <= '0;
        end else if (q.pst == PG_BUSY) begin
            busy_len_q <= busy_len_q + 20'h00001;
        end else begin
            busy_len_q <= '0;
        end
    end
    assign keep1 = mem[{buf_page, 4'h1}];

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!rst_n);

    property p_prog_time;
        q.pst == PG_BUSY |-> busy_len_q < TMR_W'(PROG_CYCLES);
    endproperty
    a_prog_time: assert property (p_prog_time) else $error("programming ran too long");

    property p_prot_block;
        (q.pst == PG_IDLE && commit_req && prot) |=> q.pst == PG_IDLE && $stable(q.progs) ##1 q.pst == PG_IDLE;
    endproperty
    a_prot_block: assert property (p_prot_block) else $error("protected write started programming");

    property p_prot_count;
        (q.pst == PG_IDLE && commit_req && prot) |=> q.blocked == $past(q.blocked) + 32'h1;
    endproperty
    a_prot_count: assert property (p_prot_count) else $error("refused write not counted");

    property p_open_write;
        (q.pst == PG_IDLE && commit_req && !prot) |=> q.pst == PG_BUSY && busy;
    endproperty
    a_open_write: assert property (p_open_write) else $error("unprotected write not programmed");

    property p_commit_byte;
        (q.pst == PG_COMMIT && buf_mask[0]) |=> mem[{$past(buf_page), 4'h0}] == $past(buf_data[0]);
    endproperty
    a_commit_byte: assert property (p_commit_byte) else $error("received byte not programmed");

    property p_partial;
        (q.pst == PG_COMMIT && !buf_mask[1]) |=> $stable(keep1);
    endproperty
    a_partial: assert property (p_partial) else $error("unreceived byte changed");

endmodule : eep_top

/* verification/eep_ctl_model.sv */
// Purpose: behavioural two-wire bus controller
// Assumes: data line resolved outside with a pull-up
// Notes:   clock stands high between frames
`timescale 1ns/1ps
module eep_ctl_model #(
    parameter int H = 16
) (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    ////////////////////////////////////////
    // one bit; data moves only while clock is low
    task automatic bit_cyc(input logic v, output logic s);
        #2 o_sda_oe = ~v;
        #(H-2) o_scl = 1'b1;
        s = i_sda;
        #(H) o_scl = 1'b0;
    endtask : bit_cyc
    // start, or repeated start from clock low
    task automatic start();
        #2 o_sda_oe = 1'b0;
        #(H) o_scl = 1'b1;
        #(3*H) o_sda_oe = 1'b1;
        #(3*H) o_scl = 1'b0;
    endtask : start
    // held long so the system clock sees the stop
    task automatic stop();
        #2 o_sda_oe = 1'b1;
        #(H) o_scl = 1'b1;
        #(3*H) o_sda_oe = 1'b0;
        #(4*H);
    endtask : stop
    // MSB first, ninth clock left to the target
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
        bit_cyc(1'b1, s);
        ack = (s === 1'b0);
    endtask : wr_byte
    task automatic rd_byte(input logic g, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            b[i] = s;
        end
        bit_cyc(~g, s);
    endtask : rd_byte
endmodule : eep_ctl_model

/* verification/serial_eeprom_slave_wp_test.sv */
// Purpose: self-checking bench of the serial memory target
// Assumes: short programming count
// Notes:   array has no reset, so reads follow writes
`timescale 1ns/1ps
module serial_eeprom_slave_wp_test;
    import eep_pkg::*;
    localparam int unsigned PN  = 100;
    localparam logic [3:0]  DEV = 4'h6; // arbitrary device-type code
    logic clk, rst_n, hsel, hwrite, hrdy, hresp, scl, sda, sda_q, oe, m_oe, wp, ack;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  rb;
    int          err_total, compares, cyc;
    eep_top #(.PROG_CYCLES(PN), .DEV_CODE(DEV)) dut (
        .I_CLK(clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hrdy),
        .O_HREADYOUT(hrdy), .O_HRDATA(hrdata), .O_HRESP(hresp), .I_SCL(scl),
        .I_SDA(sda), .O_SDA(sda_q), .O_SDA_OE(oe), .I_WP(wp));
    eep_ctl_model m (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    // wired line: low if anyone pulls, else pulled up
    assign sda = ~(oe | m_oe);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // single word transfer; each phase held until ready is seen
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic adr(input logic [2:0] pg, input logic rw, input logic e);
        m.start();
        m.wr_byte({DEV, pg, rw}, ack);
        check(ack, e);
    endtask : adr
    // write frame of n bytes counting up from v
    task automatic wr(input logic [2:0] pg, input logic [7:0] wa, input int n, input logic [7:0] v);
        adr(pg, 1'b0, 1'b1);
        m.wr_byte(wa, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.wr_byte(v + 8'(i), ack);
            check(ack, 1'b1);
        end
        m.stop();
    endtask : wr
    // random read; first byte expected in the top used lane
    task automatic rdb(input logic [2:0] pg, input logic [7:0] wa, input int n, input logic [31:0] e);
        adr(pg, 1'b0, 1'b1);
        m.wr_byte(wa, ack);
        adr(pg, 1'b1, 1'b1);
        for (int i = n - 1; i >= 0; i--) begin
            m.rd_byte(i != 0, rb);
            check(rb, e[8*i+:8]);
        end
        m.stop();
    endtask : rdb
    // bounded poll: programming must end in the scaled time
    task automatic idle();
        int k;
        k = 0;
        do begin
            ahb(1'b0, REG_STATUS, 32'h0);
            k++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && k < 45);
        check(rd[STAT_BUSY_BIT], 1'b0);
    endtask : idle
    ////////////////////////////////////////
    task automatic t_regs();
        for (int a = 0; a < 20; a += 4) begin
            ahb(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0);
        end
        check({hresp, sda_q, hrdy}, 3'h1);
        ahb(1'b1, REG_CTRL, 32'h1);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd, 32'h4);
        ahb(1'b1, REG_CTRL, 32'h0);
    endtask : t_regs
    // partial page with wrap, refused poll, then full page roll-over
    task automatic t_page();
        wr(3'h5, 8'hAE, 3, 8'hA1);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd[STAT_BUSY_BIT], 1'b1);
        adr(3'h5, 1'b0, 1'b0);
        m.stop();
        idle();
        rdb(3'h5, 8'hA0, 1, 32'hA3);
        rdb(3'h5, 8'hAE, 2, 32'hA1A2);
        wr(3'h7, 8'hF0, 17, 8'h10);
        idle();
        rdb(3'h7, 8'hF0, 1, 32'h20);
        rdb(3'h7, 8'hFE, 2, 32'h1E1F);
        ahb(1'b0, REG_PROGS, 32'h0);
        check(rd, 32'h2);
    endtask : t_page
    // pin protect: acked, nothing programmed; then a foreign type code
    task automatic t_prot();
        @(posedge clk);
        wp <= 1'b1;
        repeat (4) @(posedge clk);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd, 32'h6);
        rdb(3'h7, 8'hF0, 1, 32'h20);
        wr(3'h5, 8'hA0, 1, 8'h55);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd, 32'h6);
        ahb(1'b0, REG_BLOCKED, 32'h0);
        check(rd, 32'h1);
        rdb(3'h5, 8'hA0, 1, 32'hA3);
        @(posedge clk);
        wp <= 1'b0;
        m.start();
        m.wr_byte({~DEV, 4'h0}, ack);
        check(ack, 1'b0);
        m.stop();
    endtask : t_prot
    task automatic report_and_stop();
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {rst_n, hsel, hwrite, wp, htrans, hsize, haddr, hwdata} = {6'h0, 3'h2, 64'h0};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_page();
        t_prot();
        report_and_stop();
    end
endmodule : serial_eeprom_slave_wp_test
